/* File: emp_pkg.sv */
package emp_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int                ADDR_W      = 24;         // Address bus width
  localparam int                DATA_W      = 24;         // Data bus width
  localparam int                ATTR_N      = 4;          // Attribute lines
  localparam int                WS_W        = 4;          // Wait-state count width
  // ----------------------------------------------------------------
  // Reset values and wait-state constants
  // ----------------------------------------------------------------
  localparam logic [23:0]       ADDR_RST    = 24'h000000; // Address hold value at reset
  localparam logic [23:0]       DATA_RST    = 24'h000000; // Data out at reset
  localparam logic [3:0]        ATTR_RST    = 4'h0;       // Attribute line levels at reset
  localparam logic [3:0]        WS_ONE      = 4'h1;       // One wait state
  localparam logic [3:0]        WS_ZERO     = 4'h0;       // No wait state
  // ----------------------------------------------------------------
  // Port sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    EMP_IDLE  = 4'h1,                                     // No access
    EMP_WAIT  = 4'h2,                                     // Minimum wait states
    EMP_ACK   = 4'h4,                                     // Waiting for acknowledge
    EMP_DONE  = 4'h8                                      // Closing period
  } emp_state_e;
endpackage : emp_pkg

/* File: emp_attr_if.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Attribute line control carrier
// ------------------------------------------------------------------
interface emp_attr_if;
  logic [3:0] sel;     // Lines selected for this access
  logic [3:0] pol;     // Active level per line, 1 = active high
  logic       active;  // Access window open
  logic [3:0] level;   // Resulting pin levels
  modport ctrl (output sel, output pol, output active, input level);
  modport drv  (input sel, input pol, input active, output level);
endinterface : emp_attr_if

/* File: emp_attr_drv.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Attribute / row-strobe level generator
// ------------------------------------------------------------------
module emp_attr_drv (
  emp_attr_if.drv ai
);
  // Per-line level: active only in the access window, else inactive
  genvar g;
  for (g = 0; g < 4; g++) begin : g_line
    assign ai.level[g] = (ai.active && ai.sel[g]) ? ai.pol[g] : ~ai.pol[g];
  end
endmodule : emp_attr_drv

/* File: emp_port.sv */
`timescale 1ns/100ps
// Operation
// - Stop or Wait: release bus, tri-state outputs
// - Refresh in Wait: leave, refresh, return
// - Master drives address, else high impedance
// - Address holds value between external accesses
// - Master uses data bidirectionally, else tri-state
// - Attribute lines as chip select/address
// - Attribute lines go inactive after access
// - Attribute lines usable as row strobes
// - Software selects attribute line polarity
// - Read/write strobes while master, else tri-state
// - Cycle ends one period after acknowledge
module emp_port (
  input  wire logic        clock,            // Core clock, 100 MHz
  input  wire logic        rstn,             // Async reset, active low
  input  wire logic        bus_master,       // Device owns the external bus
  input  wire logic        stop_mode,        // Stop low-power mode
  input  wire logic        wait_mode,        // Wait low-power mode
  input  wire logic        refresh_req,      // DRAM refresh pending pulse
  input  wire logic [3:0]  refresh_rows,     // Row strobes used for refresh
  input  wire logic        req_valid,        // Core access request
  input  wire logic        req_write,        // 1 = write, 0 = read
  input  wire logic [23:0] req_addr,         // Access address
  input  wire logic [23:0] req_wdata,        // Write data
  input  wire logic [3:0]  req_attr,         // Attribute lines to assert
  input  wire logic [3:0]  req_ws,           // Minimum wait states
  input  wire logic [3:0]  attr_pol,         // Active polarity per line
  input  wire logic [3:0]  attr_ras,         // Line acts as row strobe
  output logic             req_ready,        // Access taken
  output logic             rsp_valid,        // Access finished pulse
  output logic [23:0]      rsp_rdata,        // Read data
  output logic             in_wait,          // Port is parked in Wait
  output logic [23:0]      addr_o,           // Address pins
  output logic             addr_oe,          // Address drive enable
  input  wire logic [23:0] data_i,           // Data pins in
  output logic [23:0]      data_o,           // Data pins out
  output logic             data_oe,          // Data drive enable
  output logic [3:0]       attr_select_line_o,  // Attribute/row strobe levels
  output logic             attr_select_line_oe, // Attribute drive enable
  output logic             rd_n_o,           // Read strobe, active low
  output logic             wr_n_o,           // Write strobe, active low
  output logic             strobe_oe,        // Strobe drive enable
  output logic             bus_busy_line_n_o, // Bus busy, active low
  output logic             bus_busy_line_oe, // Bus busy drive enable
  input  wire logic        transfer_ack_n    // Acknowledge pin, active low
);
  // ----------------------------------------------------------------
  // Synchronisers for pin inputs
  // ----------------------------------------------------------------
  logic        ack_s1, ack_s2;               // Acknowledge sync stages
  logic [23:0] din_s1, din_s2;               // Data sync stages
  // Two-stage capture; first stage read only by second
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_s1 <= 1'b1;
      ack_s2 <= 1'b1;
      din_s1 <= emp_pkg::DATA_RST;
      din_s2 <= emp_pkg::DATA_RST;
    end else begin
      ack_s1 <= transfer_ack_n;
      ack_s2 <= ack_s1;
      din_s1 <= data_i;
      din_s2 <= din_s1;
    end
  end
  // ----------------------------------------------------------------
  // Low-power and ownership
  // ----------------------------------------------------------------
  emp_pkg::emp_state_e state_reg;            // Sequencer state
  logic        refresh_pend_reg;             // Refresh waiting to run
  logic        cyc_refresh_reg;              // Current cycle is refresh
  logic        lp;                           // Any low-power mode
  logic        own;                          // May drive the bus
  assign lp  = stop_mode | wait_mode;
  // Wait is left only for the refresh cycle itself
  assign own = bus_master & (~lp | (wait_mode & ~stop_mode & cyc_refresh_reg));
  // Refresh pending flag; a new request wins over the clear
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      refresh_pend_reg <= 1'b0;
    end else if (refresh_req) begin
      refresh_pend_reg <= 1'b1;
    end else if (state_reg == emp_pkg::EMP_IDLE && cyc_refresh_reg) begin
      refresh_pend_reg <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Access sequencer
  // ----------------------------------------------------------------
  logic        cyc_write_reg;                // Current cycle writes
  logic [3:0]  ws_reg;                       // Remaining wait states
  logic [3:0]  cyc_attr_reg;                 // Lines for current cycle
  logic        start_acc, start_ref;         // Cycle launches
  // Refresh needs Wait only, not Stop, and bus ownership
  assign start_ref = state_reg == emp_pkg::EMP_IDLE && refresh_pend_reg && !cyc_refresh_reg
                     && bus_master && wait_mode && !stop_mode;
  assign start_acc = state_reg == emp_pkg::EMP_IDLE && req_valid && !cyc_refresh_reg
                     && bus_master && !lp && !start_ref;
  // Acknowledge is armed once it is seen released in this cycle. A low from
  // the previous cycle is still in the synchroniser when a back-to-back one starts
  logic        ack_armed_reg;                // Released acknowledge seen
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ack_armed_reg <= 1'b0;
    end else if (start_acc) begin
      ack_armed_reg <= 1'b0;
    end else if (ack_s2) begin
      ack_armed_reg <= 1'b1;
    end
  end
  // State, wait count and cycle kind
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg       <= emp_pkg::EMP_IDLE;
      ws_reg          <= emp_pkg::WS_ZERO;
      cyc_write_reg   <= 1'b0;
      cyc_attr_reg    <= emp_pkg::ATTR_RST;
      cyc_refresh_reg <= 1'b0;
    end else begin
      case (state_reg)
        emp_pkg::EMP_IDLE: begin
          cyc_refresh_reg <= 1'b0;
          if (start_ref) begin
            // Refresh: strobe the row lines, no acknowledge
            cyc_refresh_reg <= 1'b1;
            cyc_write_reg   <= 1'b0;
            cyc_attr_reg    <= refresh_rows & attr_ras;
            ws_reg          <= emp_pkg::WS_ONE;
            state_reg       <= emp_pkg::EMP_WAIT;
          end else if (start_acc) begin
            cyc_write_reg <= req_write;
            cyc_attr_reg  <= req_attr;
            ws_reg        <= req_ws;
            state_reg     <= emp_pkg::EMP_WAIT;
          end
        end
        emp_pkg::EMP_WAIT: begin
          // Minimum wait states first, then acknowledge stretch
          if (ws_reg > emp_pkg::WS_ONE) begin
            ws_reg <= ws_reg - emp_pkg::WS_ONE;
          end else if (cyc_refresh_reg || ws_reg == emp_pkg::WS_ZERO) begin
            // Zero-wait or refresh cycles cannot be stretched
            state_reg <= emp_pkg::EMP_DONE;
          end else begin
            state_reg <= emp_pkg::EMP_ACK;
          end
        end
        emp_pkg::EMP_ACK: begin
          if (ack_armed_reg && !ack_s2) begin
            state_reg <= emp_pkg::EMP_DONE;
          end
        end
        emp_pkg::EMP_DONE: begin
          state_reg <= emp_pkg::EMP_IDLE;
        end
        default: begin
          state_reg <= emp_pkg::EMP_IDLE;
        end
      endcase
    end
  end
  // ----------------------------------------------------------------
  // Core side handshake
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= emp_pkg::DATA_RST;
      in_wait   <= 1'b0;
    end else begin
      req_ready <= start_acc;
      rsp_valid <= state_reg == emp_pkg::EMP_DONE && !cyc_refresh_reg;
      if (state_reg == emp_pkg::EMP_DONE && !cyc_write_reg && !cyc_refresh_reg) begin
        rsp_rdata <= din_s2;
      end
      in_wait   <= wait_mode && !cyc_refresh_reg;
    end
  end
  // ----------------------------------------------------------------
  // Address and data pins
  // ----------------------------------------------------------------
  // Address changes only when an external access starts
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      addr_o <= emp_pkg::ADDR_RST;
    end else if (start_acc) begin
      addr_o <= req_addr;
    end
  end
  // Write data is latched at launch
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      data_o <= emp_pkg::DATA_RST;
    end else if (start_acc && req_write) begin
      data_o <= req_wdata;
    end
  end
  // Drive enables follow ownership, data only during writes
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      addr_oe             <= 1'b0;
      data_oe             <= 1'b0;
      attr_select_line_oe <= 1'b0;
      strobe_oe           <= 1'b0;
      bus_busy_line_oe    <= 1'b0;
    end else begin
      addr_oe             <= own;
      data_oe             <= own && cyc_write_reg && state_reg != emp_pkg::EMP_IDLE;
      attr_select_line_oe <= own;
      strobe_oe           <= own;
      bus_busy_line_oe    <= own;
    end
  end
  // ----------------------------------------------------------------
  // Strobes and attribute lines
  // ----------------------------------------------------------------
  logic busy;                                 // Cycle in progress
  assign busy = state_reg != emp_pkg::EMP_IDLE;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_n_o            <= 1'b1;
      wr_n_o            <= 1'b1;
      bus_busy_line_n_o <= 1'b1;
    end else begin
      rd_n_o            <= !(busy && !cyc_write_reg && !cyc_refresh_reg);
      wr_n_o            <= !(busy && cyc_write_reg);
      bus_busy_line_n_o <= !busy;
    end
  end
  emp_attr_if ai ();                          // Attribute carrier
  assign ai.sel    = cyc_attr_reg;
  assign ai.pol    = attr_pol;
  assign ai.active = busy;
  emp_attr_drv u_attr (
    .ai (ai.drv)
  );
  // Levels registered so the pins come from flip-flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      attr_select_line_o <= emp_pkg::ATTR_RST;
    end else begin
      attr_select_line_o <= ai.level;
    end
  end
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_ack_seen;
    state_reg == emp_pkg::EMP_ACK && ack_armed_reg && !ack_s2;
  endsequence
  sequence s_done;
    state_reg == emp_pkg::EMP_DONE ##1 state_reg == emp_pkg::EMP_IDLE;
  endsequence
  AST_ACK_DONE: assert property (@(posedge clock) disable iff (!rstn) s_ack_seen |=> s_done)
    else $error("Cycle did not close after acknowledge");
  AST_ACK_ARMED: assert property (@(posedge clock) disable iff (!rstn)
    state_reg == emp_pkg::EMP_ACK && !ack_armed_reg |=> state_reg == emp_pkg::EMP_ACK)
    else $error("Cycle closed on a stale acknowledge");
  AST_LP_RELEASE: assert property (@(posedge clock) disable iff (!rstn)
    stop_mode |=> !addr_oe && !strobe_oe && !data_oe)
    else $error("Bus driven in Stop");
  AST_NOT_MASTER: assert property (@(posedge clock) disable iff (!rstn)
    !bus_master |=> !addr_oe && !data_oe)
    else $error("Bus driven while not master");
  AST_ADDR_HOLD: assert property (@(posedge clock) disable iff (!rstn)
    !start_acc |=> $stable(addr_o))
    else $error("Address moved without access");
  AST_ADDR_LOAD: assert property (@(posedge clock) disable iff (!rstn)
    start_acc |=> addr_o == $past(req_addr))
    else $error("Address not loaded");
  AST_ATTR_IDLE: assert property (@(posedge clock) disable iff (!rstn)
    !busy |=> attr_select_line_o == ~$past(attr_pol))
    else $error("Attribute line left active");
  AST_ATTR_POL: assert property (@(posedge clock) disable iff (!rstn)
    busy && cyc_attr_reg[0] |=> attr_select_line_o[0] == $past(attr_pol[0]))
    else $error("Attribute polarity wrong");
  AST_WR_STROBE: assert property (@(posedge clock) disable iff (!rstn)
    busy && cyc_write_reg |=> !wr_n_o && rd_n_o)
    else $error("Write strobe wrong");
  AST_REFRESH: assert property (@(posedge clock) disable iff (!rstn)
    start_ref |=> cyc_refresh_reg ##[1:4] state_reg == emp_pkg::EMP_IDLE)
    else $error("Refresh did not finish");
  AST_RAS: assert property (@(posedge clock) disable iff (!rstn)
    start_ref |=> cyc_attr_reg == $past(refresh_rows & attr_ras))
    else $error("Row strobes wrong");
  AST_ATTR_SEL: assert property (@(posedge clock) disable iff (!rstn)
    start_acc |=> cyc_attr_reg == $past(req_attr))
    else $error("Attribute select not taken");
  AST_DATA_OE: assert property (@(posedge clock) disable iff (!rstn)
    data_oe |-> $past(cyc_write_reg))
    else $error("Data driven on read");
endmodule : emp_port

/* File: emp_mem_model.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Far-side memory: answers strobes, stretches with acknowledge
// ------------------------------------------------------------------
module emp_mem_model (
  input  wire logic        clock,    // Bus clock
  input  wire logic        rstn,     // Async reset, active low
  input  wire logic        rd_n,     // Read strobe from the port
  input  wire logic        wr_n,     // Write strobe from the port
  input  wire logic        strobe_oe, // Strobes driven
  input  wire logic [23:0] addr,     // Address pins
  input  wire logic [23:0] wdata,    // Data pins from the port
  input  wire logic [3:0]  ack_dly,  // Cycles before acknowledge
  output logic      [23:0] rdata,    // Data pins towards the port
  output logic             ack_n     // Acknowledge, pulled up when idle
);
  logic [23:0] mem [16];             // Small store, low address bits only
  logic [3:0]  cnt_reg;              // Cycles since strobe seen
  logic [23:0] last_reg;             // Last word driven
  wire         active = strobe_oe && !(rd_n && wr_n); // Access running
  // Acknowledge after a chosen delay, held until the strobe ends
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= 4'h0;
      ack_n   <= 1'b1;
    end else if (!active) begin
      cnt_reg <= 4'h0;
      ack_n   <= 1'b1;
    end else if (cnt_reg >= ack_dly) begin
      ack_n   <= 1'b0;
    end else begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end
  // Write lands once acknowledged
  always_ff @(posedge clock) begin
    if (active && !wr_n && !ack_n) begin
      mem[addr[3:0]] <= wdata;
    end
  end
  // Released data shows the inverse so a stale word never passes
  always_ff @(posedge clock) begin
    if (active && !rd_n) begin
      rdata    <= mem[addr[3:0]];
      last_reg <= mem[addr[3:0]];
    end else begin
      rdata    <= ~last_reg;
    end
  end
endmodule : emp_mem_model

/* File: external_memory_port_bus_tb.sv */
`timescale 1ns/100ps
module external_memory_port_bus_tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic        clock, rstn, bus_master, stop_mode, wait_mode;
  logic        refresh_req, req_valid, req_write, req_ready, rsp_valid;
  logic        in_wait, addr_oe, data_oe, attr_oe, rd_n, wr_n;
  logic        strobe_oe, busy_n, busy_oe, ack_n;
  logic [3:0]  refresh_rows, req_attr, req_ws, attr_pol, attr_ras;
  logic [3:0]  ack_dly, attr_o, seen_attr;
  logic [23:0] req_addr, req_wdata, data_i, rsp_rdata, addr_o, data_o;
  logic [3:0]  seen_oe;              // Drive enables and bus busy seen mid-access
  int          fails, checks, lat, lat1;
  emp_port u_emp_port (.clock(clock), .rstn(rstn), .bus_master(bus_master),
    .stop_mode(stop_mode), .wait_mode(wait_mode), .refresh_req(refresh_req),
    .refresh_rows(refresh_rows), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_attr(req_attr), .req_ws(req_ws),
    .attr_pol(attr_pol), .attr_ras(attr_ras), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .in_wait(in_wait), .addr_o(addr_o),
    .addr_oe(addr_oe), .data_i(data_i), .data_o(data_o), .data_oe(data_oe),
    .attr_select_line_o(attr_o), .attr_select_line_oe(attr_oe), .rd_n_o(rd_n),
    .wr_n_o(wr_n), .strobe_oe(strobe_oe), .bus_busy_line_n_o(busy_n),
    .bus_busy_line_oe(busy_oe), .transfer_ack_n(ack_n));
  emp_mem_model u_emp_mem_model (.clock(clock), .rstn(rstn), .rd_n(rd_n), .wr_n(wr_n),
    .strobe_oe(strobe_oe), .addr(addr_o), .wdata(data_o), .ack_dly(ack_dly),
    .rdata(data_i), .ack_n(ack_n));
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Single compare for every value kind
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic print_verdict();
    if (fails == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  // All drive enables together, zero when the bus is released
  function automatic logic [23:0] oes();
    return {19'h0, addr_oe, data_oe, attr_oe, strobe_oe, busy_oe};
  endfunction : oes
  // One access; request held until ready is sampled, bounded waits
  task automatic access(input logic wr, input logic [23:0] a, input logic [23:0] d,
                        input logic [3:0] at, input logic [3:0] ws);
    int i;
    req_valid <= 1'b1;
    req_write <= wr;
    req_addr  <= a;
    req_wdata <= d;
    req_attr  <= at;
    req_ws    <= ws;
    i = 0;
    do begin tick(1); i++; end while (req_ready !== 1'b1 && i < 50);
    req_valid <= 1'b0;
    lat = 0;
    do begin
      tick(1);
      lat++;
      if (!rd_n || !wr_n) begin
        seen_attr = attr_o;
        seen_oe   = {addr_oe, data_oe, strobe_oe, ~busy_n};
      end
    end while (rsp_valid !== 1'b1 && lat < 60);
    // A hang counts as a mismatch and closes the run
    if (req_ready !== 1'b1 && i >= 50 || lat >= 60) begin
      fails++;
      print_verdict();
    end
  endtask : access
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Write then read back; attribute levels follow polarity
  task automatic s_write_read();
    access(1'b1, 24'h012345, 24'hABCDEF, 4'h3, 4'h1);
    chk(seen_oe, 24'hF);
    chk(seen_attr, 24'h6);
    tick(3);
    chk(attr_o, 24'h5);
    chk(addr_o, 24'h012345);
    access(1'b0, 24'h012345, 24'h000000, 4'h1, 4'h2);
    chk(rsp_rdata, 24'hABCDEF);
    chk(seen_attr, 24'h4);
    chk(seen_oe, 24'hB);
  endtask : s_write_read
  // Longer acknowledge delay stretches the cycle by exactly that much
  task automatic s_latency();
    ack_dly <= 4'h1;
    access(1'b0, 24'h012345, 24'h000000, 4'h0, 4'h1);
    lat1 = lat;
    ack_dly <= 4'h5;
    access(1'b0, 24'h012345, 24'h000000, 4'h0, 4'h1);
    chk(24'(lat - lat1), 24'h4);
    chk(rsp_rdata, 24'hABCDEF);
    // Zero wait states cannot be stretched: length fixed whatever the delay
    access(1'b0, 24'h012345, 24'h000000, 4'h0, 4'h0);
    chk(24'(lat), 24'h2);
  endtask : s_latency
  // Without mastership the bus floats and requests wait
  task automatic s_not_master();
    int i;
    bus_master <= 1'b0;
    tick(3);
    chk(oes(), 24'h0);
    req_valid <= 1'b1;
    for (i = 0; i < 6; i++) begin
      tick(1);
      chk(req_ready, 24'h0);
    end
    req_valid  <= 1'b0;
    bus_master <= 1'b1;
    tick(2);
  endtask : s_not_master
  // Stop mode releases the bus
  task automatic s_stop();
    stop_mode <= 1'b1;
    tick(3);
    chk(oes(), 24'h0);
    stop_mode <= 1'b0;
    tick(2);
  endtask : s_stop
  // Wait mode parks; a refresh leaves it, strobes a row, then returns
  task automatic s_wait_refresh();
    int i;
    logic seen;
    logic left;
    wait_mode <= 1'b1;
    tick(3);
    chk(in_wait, 24'h1);
    chk(oes(), 24'h0);
    attr_ras     <= 4'h1;
    refresh_rows <= 4'h1;
    refresh_req  <= 1'b1;
    tick(1);
    refresh_req  <= 1'b0;
    seen = 1'b0;
    left = 1'b0;
    for (i = 0; i < 20; i++) begin
      tick(1);
      if (attr_oe === 1'b1 && attr_o[0] === 1'b0) seen = 1'b1;
      if (in_wait === 1'b0) left = 1'b1;
    end
    chk(seen, 24'h1);
    chk(left, 24'h1);
    chk(in_wait, 24'h1);
    wait_mode <= 1'b0;
    attr_ras  <= 4'h0;
    tick(2);
  endtask : s_wait_refresh
  // ----------------------------------------------------------------
  // Clock and main sequence
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  initial begin
    fails = 0;
    checks = 0;
    {rstn, stop_mode, wait_mode, refresh_req, req_valid, req_write} = 6'h00;
    bus_master = 1'b1;
    {refresh_rows, req_attr, attr_ras} = 12'h000;
    {req_ws, attr_pol, ack_dly} = 12'h1A2;
    {req_addr, req_wdata} = 48'h0;
    tick(20);
    rstn <= 1'b1;
    tick(2);
    s_write_read();
    s_latency();
    s_not_master();
    s_stop();
    s_wait_refresh();
    print_verdict();
  end
endmodule : external_memory_port_bus_tb
